// File: src/spp_pkg.sv
// Constants shared by the serial peripheral port design.
package spp_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_PORT_A_DIR = 8'h85;
	localparam logic [7:0] IDX_PORT_C_DIR = 8'h87;
	localparam logic [7:0] IDX_FLAGS = 8'h0c;
	localparam logic [7:0] IDX_BUF = 8'h13;
	localparam logic [7:0] IDX_CTRL = 8'h14;
	localparam logic [7:0] IDX_ENABLES = 8'h8c;
	localparam logic [7:0] IDX_STATUS = 8'h94;
	localparam logic [7:0] IDX_PIN_DATA = 8'h95;
	// Control register fields.
	localparam int CTRL_WRITE_COLLISION_FLAG = 7;
	localparam int CTRL_OVF = 6;
	localparam int CTRL_EN = 5;
	localparam int CTRL_CKP = 4;
	// Status register fields.
	localparam int STAT_SMP = 7;
	localparam int STAT_CKE = 6;
	localparam int STAT_BF = 0;
	// Interrupt flag and enable position of the serial port.
	localparam int FLAG_SERIAL = 3;
	localparam logic [7:0] FLAGS_MASK = 8'hcf;
	// Direction bits: port C bits 3..5, port A bit 5.
	localparam int DIR_SCK = 3;
	localparam int DIR_SDI = 4;
	localparam int DIR_SDO = 5;
	localparam int DIR_SS = 5;
	// Pin data bits used while a pin is a general purpose output.
	localparam int PD_SCK = 0;
	localparam int PD_SDI = 1;
	localparam int PD_SDO = 2;
	localparam int PD_SS = 3;
	// Values after reset.
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [5:0] RST_DIR = 6'h3f;
	// Mode field encodings.
	localparam logic [3:0] MODE_M_DIV4 = 4'h0;
	localparam logic [3:0] MODE_M_DIV16 = 4'h1;
	localparam logic [3:0] MODE_M_DIV64 = 4'h2;
	localparam logic [3:0] MODE_M_TIMER = 4'h3;
	localparam logic [3:0] MODE_S_GATED = 4'h4;
	localparam logic [3:0] MODE_S_FREE = 4'h5;
	// Half bit periods in core clocks for the divided master rates.
	localparam logic [5:0] HALF_DIV4 = 6'd2;
	localparam logic [5:0] HALF_DIV16 = 6'd8;
	localparam logic [5:0] HALF_DIV64 = 6'd32;
	// Index of the last clock toggle of a byte and the index of the last bit.
	localparam logic [4:0] LAST_TOGGLE = 5'd15;
	localparam logic [2:0] LAST_BIT = 3'd7;
endpackage : spp_pkg

// File: src/spp_shift_if.sv
// Link between the port control logic and its shift register.
`timescale 1ns/1ps
interface spp_shift_if;
	logic clear;
	logic load;
	logic [7:0] load_data;
	logic sample;
	logic shift;
	logic sin;
	logic sout;
	logic done;
	logic idle;
	logic [7:0] rx_data;
	modport ctrl (
		output clear, load, load_data, sample, shift, sin,
		input sout, done, idle, rx_data
	);
	modport shifter (
		input clear, load, load_data, sample, shift, sin,
		output sout, done, idle, rx_data
	);
endinterface : spp_shift_if

// File: src/spp_shifter.sv
// Eight bit serial shift register, most significant bit first.
`timescale 1ns/1ps
module spp_shifter (
	input wire logic clk_i,
	input wire logic rst_i,
	spp_shift_if.shifter sh
);
	logic [7:0] sr_q;
	logic [2:0] cnt_q;
	logic sout_q;
	wire logic [7:0] sr_next = {sr_q[6:0], sh.sin};

	assign sh.rx_data = sr_next;
	assign sh.sout = sout_q;
	assign sh.idle = (cnt_q == 3'h0);
	assign sh.done = sh.sample & (cnt_q == spp_pkg::LAST_BIT); // R8

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_q <= spp_pkg::RST_REG;
			cnt_q <= 3'h0;
			sout_q <= 1'b0;
		end else if (sh.load) begin
			sr_q <= sh.load_data;
			sout_q <= sh.load_data[7]; // R10
			cnt_q <= 3'h0;
		end else if (sh.clear) begin
			// A deselect drops the partial count but keeps a word preloaded for the next frame.
			cnt_q <= 3'h0; // R15
			sout_q <= sr_q[7];
		end else begin
			if (sh.sample) begin
				sr_q <= sr_next; // R10
				cnt_q <= cnt_q + 3'h1;
			end
			if (sh.shift) begin
				// A sample in the same cycle already moved the next bit up.
				sout_q <= sh.sample ? sr_next[7] : sr_q[7]; // R5
			end
		end
	end

	a_msb_leads_out: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		sh.load |=> sout_q == $past(sh.load_data[7]))
		else $error("First output bit is not the top bit of the loaded word.");
	a_count_wraps_done: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		sh.done && !sh.clear && !sh.load |=> cnt_q == 3'h0 && sr_q == $past(sr_next))
		else $error("Bit count did not restart after the eighth bit.");
endmodule : spp_shifter

// File: src/spp_spi_port.sv
// Serial peripheral port in its SPI role with a classic Wishbone register slave.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
// Contract
// [R1] Shift register reachable only through transfer buffer.
// [R2] Port runs only while enable bit set.
// [R3] Software sets pin directions for serial roles.
// [R4] Opposite direction bit turns pin into output.
// [R5] Shift on programmed edge, capture on opposite.
// [R6] Master buffer write starts eight bit exchange.
// [R7] Master with clock input keeps receiving bytes.
// [R8] Slave shifts on external clock, flags eighth.
// [R9] Clock idle level follows polarity bit.
// [R10] Words travel most significant bit first.
// [R11] Master rate: four, sixteen, sixtyfour, timer/2.
// [R12] Slave works in sleep and wakes device.
// [R13] Gated slave needs mode four, select input.
// [R14] Select low drives output; high floats it.
// [R15] Select high resets gated slave logic.
// [R16] Slave with edge select one needs gating.
// [R17] Output pin as input stops transmit drive.
// [R18] Received byte fills buffer, sets full, flag.
// [R19] Write during exchange ignored, sets collision.
// [R20] Mode codes zero to three master, four/five slave.
// [R21] Slave byte into full buffer sets overflow.
// [R22] Clock and select pins synchronised, edges detected.
module spp_spi_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic sdi_i,
	output logic sdi_o,
	output logic sdi_oe_o,
	input wire logic sdo_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic ss_n_i,
	output logic ss_n_o,
	output logic ss_n_oe_o,
	input wire logic sleep_i,
	input wire logic period_timer_tick_i,
	output logic wake_o
);
	typedef enum logic {SPP_IDLE, SPP_RUN} spp_mst_e;

	spp_shift_if sh ();

	spp_shifter u_shifter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sh(sh.shifter)
	);

	// Pin synchronisers: bit 2 clock, bit 1 select, bit 0 data in; reset shows idle pins.
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic sck_prev_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 3'h2;
			sync_q <= 3'h2;
			sck_prev_q <= 1'b0;
		end else begin
			meta_q <= {sck_i, ss_n_i, sdi_i}; // R22
			sync_q <= meta_q; // R22
			sck_prev_q <= sync_q[2];
		end
	end

	wire logic sck_sync = sync_q[2];
	wire logic ss_high = sync_q[1];
	wire logic sdi_sync = sync_q[0];
	wire logic s_rise = sck_sync & ~sck_prev_q; // R22
	wire logic s_fall = ~sck_sync & sck_prev_q; // R22

	// Registers.
	logic ack_q;
	logic [31:0] dat_q;
	logic [5:0] ctrl_q;
	logic write_collision_flag_q;
	logic ovf_q;
	logic [1:0] stat_q;
	logic bf_q;
	logic [7:0] flags_q;
	logic [7:0] ena_q;
	logic [7:0] buf_q;
	logic [5:0] dir_a_q;
	logic [5:0] dir_c_q;
	logic [3:0] pdat_q;
	logic wake_q;

	// Bus decode.
	wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire logic bus_rd = bus_req & ~wb_we_i;
	wire logic [7:0] idx = wb_adr_i[9:2];
	wire logic hit_flags = idx == spp_pkg::IDX_FLAGS;
	wire logic hit_buf = idx == spp_pkg::IDX_BUF;
	wire logic hit_ctrl = idx == spp_pkg::IDX_CTRL;
	wire logic hit_ena = idx == spp_pkg::IDX_ENABLES;
	wire logic hit_stat = idx == spp_pkg::IDX_STATUS;
	wire logic hit_dir_a = idx == spp_pkg::IDX_PORT_A_DIR;
	wire logic hit_dir_c = idx == spp_pkg::IDX_PORT_C_DIR;
	wire logic hit_pdat = idx == spp_pkg::IDX_PIN_DATA;
	wire logic [7:0] wdat = wb_dat_i[7:0];

	// Mode decode.
	wire logic en = ctrl_q[spp_pkg::CTRL_EN]; // R2
	wire logic clock_idle_polarity = ctrl_q[spp_pkg::CTRL_CKP];
	wire logic [3:0] mode = ctrl_q[3:0];
	wire logic input_sample_phase = stat_q[1];
	wire logic cke = stat_q[0];
	wire logic is_master = en & (mode[3:2] == 2'b00); // R20
	wire logic is_slave = en & ((mode == spp_pkg::MODE_S_GATED) |
		(mode == spp_pkg::MODE_S_FREE)); // R20
	wire logic gated = en & (mode == spp_pkg::MODE_S_GATED) &
		dir_a_q[spp_pkg::DIR_SS]; // R13
	wire logic slave_hold = gated & ss_high; // R15
	wire logic tx_on_rise = clock_idle_polarity ^ cke; // R5
	wire logic sck_dir_in = dir_c_q[spp_pkg::DIR_SCK];

	// Master bit clock generator.
	spp_mst_e mst_q;
	logic [5:0] half_cnt_q;
	logic [4:0] tog_cnt_q;
	logic sck_int_q;

	wire logic mst_busy = mst_q == SPP_RUN;
	wire logic slv_busy = is_slave & ~sh.idle;
	wire logic xfer_busy = mst_busy | slv_busy;
	wire logic buf_wr = bus_wr & hit_buf;
	wire logic buf_wr_ok = buf_wr & ~xfer_busy; // R19
	wire logic [5:0] half_len = (mode == spp_pkg::MODE_M_DIV4) ? spp_pkg::HALF_DIV4 :
		(mode == spp_pkg::MODE_M_DIV16) ? spp_pkg::HALF_DIV16 :
		spp_pkg::HALF_DIV64; // R11
	wire logic half_end = half_cnt_q == (half_len - 6'd1);
	wire logic m_tick = (mode == spp_pkg::MODE_M_TIMER) ?
		period_timer_tick_i : half_end; // R11
	wire logic m_tog = mst_busy & m_tick & ~sleep_i;
	wire logic m_rise = m_tog & ~sck_int_q;
	wire logic m_is_shift = m_rise ? tx_on_rise : ~tx_on_rise;
	wire logic m_start = is_master & ~mst_busy & ~sleep_i &
		(buf_wr_ok | sck_dir_in); // R6 R7
	wire logic m_last = m_tog & (tog_cnt_q == spp_pkg::LAST_TOGGLE);

	always_ff @(posedge clk_i) begin
		if (rst_i || !is_master) begin
			mst_q <= SPP_IDLE; // R2
			half_cnt_q <= 6'h0;
			tog_cnt_q <= 5'h0;
			sck_int_q <= clock_idle_polarity;
		end else begin
			unique case (mst_q)
				SPP_IDLE: begin
					sck_int_q <= clock_idle_polarity; // R9
					half_cnt_q <= 6'h0;
					tog_cnt_q <= 5'h0;
					if (m_start) begin
						mst_q <= SPP_RUN; // R6
					end
				end
				SPP_RUN: begin
					half_cnt_q <= (m_tick || sleep_i) ? 6'h0 : half_cnt_q + 6'h1;
					if (m_tog) begin
						sck_int_q <= ~sck_int_q;
						tog_cnt_q <= tog_cnt_q + 5'h1;
					end
					if (m_last) begin
						mst_q <= SPP_IDLE;
					end
				end
			endcase
		end
	end

	// Shift and sample strobes.
	wire logic s_act = is_slave & ~slave_hold; // R14
	wire logic s_shift = s_act & (tx_on_rise ? s_rise : s_fall); // R5 R8
	wire logic s_sample = s_act & (tx_on_rise ? s_fall : s_rise); // R5 R8
	wire logic m_shift = m_tog & m_is_shift; // R5
	wire logic m_sample = input_sample_phase ? (m_tog & tog_cnt_q[0]) : (m_tog & ~m_is_shift);

	assign sh.clear = ~en | slave_hold; // R2 R15
	assign sh.load = buf_wr_ok & en; // R1
	assign sh.load_data = wdat;
	assign sh.shift = m_shift | s_shift;
	assign sh.sample = m_sample | s_sample;
	assign sh.sin = sdi_sync;

	wire logic done = sh.done & en;
	wire logic rx_drop = done & is_slave & bf_q; // R21
	wire logic rx_keep = done & ~rx_drop; // R18

	// Bus registers and flags.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= spp_pkg::RST_REG[5:0];
			stat_q <= 2'b00;
			ena_q <= spp_pkg::RST_REG;
			dir_a_q <= spp_pkg::RST_DIR;
			dir_c_q <= spp_pkg::RST_DIR;
			pdat_q <= 4'h0;
		end else if (bus_wr) begin
			if (hit_ctrl) begin
				ctrl_q <= wdat[5:0]; // R2
			end
			if (hit_stat) begin
				stat_q <= wdat[spp_pkg::STAT_SMP:spp_pkg::STAT_CKE];
			end
			if (hit_ena) begin
				ena_q <= wdat & spp_pkg::FLAGS_MASK;
			end
			if (hit_dir_a) begin
				dir_a_q <= wdat[5:0];
			end
			if (hit_dir_c) begin
				dir_c_q <= wdat[5:0];
			end
			if (hit_pdat) begin
				pdat_q <= wdat[3:0];
			end
		end
	end

	wire logic wr_ctrl = bus_wr & hit_ctrl;
	wire logic wr_flags = bus_wr & hit_flags;
	wire logic rd_buf = bus_rd & hit_buf;
	wire logic [7:0] flags_sw = wr_flags ? (wdat & spp_pkg::FLAGS_MASK) : flags_q;

	// Hardware sets win over software clears in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_collision_flag_q <= 1'b0;
			ovf_q <= 1'b0;
			bf_q <= 1'b0;
			flags_q <= spp_pkg::RST_REG;
			buf_q <= spp_pkg::RST_REG;
			wake_q <= 1'b0;
		end else begin
			write_collision_flag_q <= (buf_wr & xfer_busy) |
				(wr_ctrl ? wdat[spp_pkg::CTRL_WRITE_COLLISION_FLAG] : write_collision_flag_q); // R19
			ovf_q <= rx_drop | (wr_ctrl ? wdat[spp_pkg::CTRL_OVF] : ovf_q); // R21
			bf_q <= rx_keep | (bf_q & ~rd_buf); // R18
			flags_q <= flags_sw | ({7'h0, done} << spp_pkg::FLAG_SERIAL); // R8 R18
			if (rx_keep) begin
				buf_q <= sh.rx_data; // R18
			end else if (buf_wr_ok) begin
				buf_q <= wdat;
			end
			wake_q <= sleep_i & (wake_q | (done & is_slave)); // R12
		end
	end

	// Read multiplexer; unmapped indices read as zero.
	wire logic [7:0] ctrl_rd = {write_collision_flag_q, ovf_q, ctrl_q};
	wire logic [7:0] stat_rd = {stat_q, 5'h00, bf_q};
	wire logic [7:0] rd_mux = hit_flags ? flags_q :
		hit_buf ? buf_q :
		hit_ctrl ? ctrl_rd :
		hit_ena ? ena_q :
		hit_stat ? stat_rd :
		hit_dir_a ? {2'b00, dir_a_q} :
		hit_dir_c ? {2'b00, dir_c_q} :
		hit_pdat ? {4'h0, pdat_q} : 8'h00; // R1

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= bus_req;
			dat_q <= bus_rd ? {24'h0, rd_mux} : 32'h0;
		end
	end

	// Pin drivers: a cleared direction bit makes the pin an output.
	wire logic sck_serial = is_master & ~sck_dir_in;
	wire logic sdo_serial = en & ~dir_c_q[spp_pkg::DIR_SDO];
	wire logic sck_o_d = sck_serial ? sck_int_q : pdat_q[spp_pkg::PD_SCK]; // R9 R4
	wire logic sdo_o_d = sdo_serial ? sh.sout : pdat_q[spp_pkg::PD_SDO]; // R4
	wire logic sdo_oe_d = ~dir_c_q[spp_pkg::DIR_SDO] & ~slave_hold; // R14 R17
	logic sck_q;
	logic sck_oe_q;
	logic sdi_q;
	logic sdi_oe_q;
	logic sdo_q;
	logic sdo_oe_q;
	logic ss_q;
	logic ss_oe_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_q <= 1'b0;
			sck_oe_q <= 1'b0;
			sdi_q <= 1'b0;
			sdi_oe_q <= 1'b0;
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
			ss_q <= 1'b0;
			ss_oe_q <= 1'b0;
		end else begin
			sck_q <= sck_o_d;
			sck_oe_q <= ~dir_c_q[spp_pkg::DIR_SCK]; // R4
			sdi_q <= pdat_q[spp_pkg::PD_SDI];
			sdi_oe_q <= ~dir_c_q[spp_pkg::DIR_SDI]; // R4
			sdo_q <= sdo_o_d;
			sdo_oe_q <= sdo_oe_d; // R14 R17
			ss_q <= pdat_q[spp_pkg::PD_SS];
			ss_oe_q <= ~dir_a_q[spp_pkg::DIR_SS]; // R4
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign sck_o = sck_q;
	assign sck_oe_o = sck_oe_q;
	assign sdi_o = sdi_q;
	assign sdi_oe_o = sdi_oe_q;
	assign sdo_o = sdo_q;
	assign sdo_oe_o = sdo_oe_q;
	assign ss_n_o = ss_q;
	assign ss_n_oe_o = ss_oe_q;
	assign wake_o = wake_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_busy_buf_write;
		buf_wr && xfer_busy;
	endsequence

	a_ack_single_pulse: assert property (ack_q |=> !ack_q)
		else $error("Bus acknowledge lasted more than one cycle.");
	a_write_collision_flag_on_busy: assert property (s_busy_buf_write |=> write_collision_flag_q) // R19
		else $error("Busy buffer write did not raise write collision.");
	a_busy_write_dropped: assert property (s_busy_buf_write |-> !sh.load) // R19
		else $error("Busy buffer write reached the shift register.");
	a_rx_fills_buf: assert property (rx_keep |=> bf_q && flags_q[3] &&
		buf_q == $past(sh.rx_data)) // R18
		else $error("Received byte did not fill the buffer.");
	a_slave_overflow: assert property (rx_drop |=> ovf_q && $stable(buf_q)) // R21
		else $error("Slave overrun did not set overflow or kept new byte.");
	a_master_no_ovf: assert property (done && is_master |-> !rx_drop) // R21
		else $error("Master mode produced an overflow.");
	a_select_floats: assert property (slave_hold |=> !sdo_oe_o) // R14
		else $error("Output kept driving while deselected.");
	a_sdo_input_off: assert property (dir_c_q[5] |=> !sdo_oe_o) // R17
		else $error("Output pin driven while set as input.");
	a_idle_polarity: assert property (sck_serial && !mst_busy && $stable(clock_idle_polarity)
		|=> sck_o == $past(clock_idle_polarity)) // R9
		else $error("Idle clock level does not match polarity bit.");
	a_disable_stops: assert property (!en |=> !mst_busy && sh.idle) // R2
		else $error("Port kept running while disabled.");
	a_master_starts: assert property (buf_wr_ok && is_master && !sleep_i
		|=> mst_busy ##0 sh.idle) // R6
		else $error("Master write did not start an exchange.");
	a_byte_sixteen_edges: assert property (m_last |=> !mst_busy ##1 sck_o == clock_idle_polarity) // R9
		else $error("Clock did not return to idle after the byte.");
endmodule : spp_spi_port

// File: sim/spp_far_end.sv
// Behavioural far-end SPI device, answering as slave or driving frames as master.
`timescale 1ns/1ps
module spp_far_end (
	input wire logic sck_i,
	input wire logic din_i,
	output logic dout_o,
	output logic sck_o,
	output logic ss_n_o
);
	logic cpol;
	logic [7:0] tx;
	logic [7:0] rx;
	int cnt;
	initial begin
		cpol = 1'b0;
		tx = 8'h00;
		rx = 8'h00;
		cnt = 8;
		dout_o = 1'b0;
		sck_o = 1'b0;
		ss_n_o = 1'b1;
	end
	// Capture on the edge that leaves idle, shift on the edge back to idle.
	always @(sck_i) begin
		if (sck_i !== cpol) begin
			rx = {rx[6:0], din_i};
		end else if (cnt < 8) begin
			cnt = cnt + 1;
			tx = {tx[6:0], 1'b0};
			dout_o = (cnt < 8) ? tx[7] : ~dout_o;
		end
	end
	// Same clock polarity as the port; moving the clock to idle is not a shift edge.
	task automatic load(input logic [7:0] b, input logic pol);
		cnt = 8;
		cpol = pol;
		sck_o = pol;
		#1;
		tx = b;
		dout_o = b[7];
		cnt = 0;
	endtask : load
	// Clock stands at idle outside frames; select frames every transfer.
	task automatic frame(input int nbits, input int half);
		#1;
		ss_n_o = 1'b0;
		#(half);
		for (int i = 0; i < 2 * nbits; i++) begin
			sck_o = ~sck_o;
			#(half);
		end
		ss_n_o = 1'b1;
		dout_o = ~dout_o;
	endtask : frame
endmodule : spp_far_end

// File: sim/testbench.sv
// Self-checking bench for the serial peripheral port over Wishbone.
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, sck_o, sck_oe_o, sdi_o, sdi_oe_o, sdo_o, sdo_oe_o, ss_n_o, ss_n_oe_o, wake_o;
	logic sleep_i = 1'b0;
	logic period_timer_tick_i = 1'b0;
	logic far_dout, far_sck, far_ss, pat = 1'b0;
	logic sck_w, sdi_w, sdo_w, ss_w, pol;
	logic [1:0] tick_cnt = 2'd0;
	logic [3:0] mode;
	logic [7:0] q;
	logic [31:0] rnd = 32'h7dedb5ab;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	int halfs[5] = '{2, 8, 32, 3, 2};
	assign sck_w = sck_oe_o ? sck_o : far_sck;
	assign sdi_w = sdi_oe_o ? sdi_o : far_dout;
	assign sdo_w = sdo_oe_o ? sdo_o : pat;
	assign ss_w = ss_n_oe_o ? ss_n_o : far_ss;
	always #50 clk_i = ~clk_i;
	spp_spi_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_o(sck_oe_o), .sdi_i(sdi_w), .sdi_o(sdi_o), .sdi_oe_o(sdi_oe_o), .sdo_i(sdo_w),
		.sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
		.ss_n_oe_o(ss_n_oe_o), .sleep_i(sleep_i), .period_timer_tick_i(period_timer_tick_i),
		.wake_o(wake_o));
	spp_far_end far (.sck_i(sck_w), .din_i(sdo_w), .dout_o(far_dout), .sck_o(far_sck),
		.ss_n_o(far_ss));
	// Undriven output line toggles so a stale level never looks valid.
	always @(posedge clk_i) begin
		pat <= ~pat;
		tick_cnt <= (tick_cnt == 2'd2) ? 2'd0 : tick_cnt + 2'd1;
		period_timer_tick_i <= (tick_cnt == 2'd2);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (!e[32]) check(wb_dat_o, e[31:0]);
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask : check
	task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] d,
		input logic [32:0] ex, output logic [7:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		if (!we) exp_q.push_back(ex);
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		r = wb_dat_o[7:0];
		if (k >= 50) errors++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d, 33'h0, q);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
		bus(idx, 1'b0, 8'h00, {9'h0, 16'h0, ex}, q);
	endtask : rd
	task automatic wait_lvl(input logic v);
		while (sck_o !== v && n < 300) begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_lvl
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(spp_pkg::IDX_CTRL, 8'h00);
		rd(spp_pkg::IDX_STATUS, 8'h00);
		rd(spp_pkg::IDX_FLAGS, 8'h00);
		rd(spp_pkg::IDX_PORT_C_DIR, 8'h3f);
		rd(8'h40, 8'h00);
		wr(spp_pkg::IDX_ENABLES, 8'hff);
		rd(spp_pkg::IDX_ENABLES, 8'hcf);
		$display("test registers done");
		wr(spp_pkg::IDX_PORT_C_DIR, 8'h17);
		// End-of-bit sampling leaves room for the pin round trip at the fast rates.
		wr(spp_pkg::IDX_STATUS, 8'h80);
		for (int i = 0; i < 5; i++) begin
			mode = (i == 4) ? 4'h0 : i[3:0];
			pol = (i == 4);
			wr(spp_pkg::IDX_CTRL, {3'b000, pol, mode});
			wr(spp_pkg::IDX_CTRL, {3'b001, pol, mode});
			@(posedge clk_i);
			rnd = xs(rnd);
			far.load(rnd[15:8], pol);
			check({31'h0, sck_o}, {31'h0, pol});
			wr(spp_pkg::IDX_BUF, rnd[7:0]);
			n = 0;
			wait_lvl(~pol);
			n = 0;
			wait_lvl(pol);
			wait_lvl(~pol);
			check(n, 2 * halfs[i]);
			if (i == 0) wr(spp_pkg::IDX_BUF, ~rnd[7:0]);
			q = 8'h00;
			for (int k = 0; k < 400 && q[0] !== 1'b1; k++)
				bus(spp_pkg::IDX_STATUS, 1'b0, 8'h00, {1'b1, 32'h0}, q);
			rd(spp_pkg::IDX_BUF, rnd[15:8]);
			check({24'h0, far.rx}, {24'h0, rnd[7:0]});
			rd(spp_pkg::IDX_CTRL, {(i == 0), 2'b01, pol, mode});
			rd(spp_pkg::IDX_FLAGS, 8'h08);
			rd(spp_pkg::IDX_STATUS, 8'h80);
			wr(spp_pkg::IDX_FLAGS, 8'h00);
		end
		$display("test master rates done");
		wr(spp_pkg::IDX_PORT_A_DIR, 8'h1f);
		wr(spp_pkg::IDX_PIN_DATA, 8'h08);
		wr(spp_pkg::IDX_PORT_C_DIR, 8'h3f);
		repeat (2) @(posedge clk_i);
		check({30'h0, ss_n_oe_o, ss_n_o}, 32'h3);
		check({31'h0, sdo_oe_o}, 32'h0);
		wr(spp_pkg::IDX_PORT_A_DIR, 8'h3f);
		$display("test pin override done");
		// The far clock goes idle before the slave listens, so no stray edge is seen.
		far.load(8'hc3, 1'b0);
		wr(spp_pkg::IDX_STATUS, 8'h00);
		wr(spp_pkg::IDX_PORT_C_DIR, 8'h1f);
		wr(spp_pkg::IDX_CTRL, 8'h05);
		wr(spp_pkg::IDX_CTRL, 8'h25);
		wr(spp_pkg::IDX_BUF, 8'h5a);
		sleep_i <= 1'b1;
		far.frame(8, 800);
		repeat (8) @(posedge clk_i);
		check({31'h0, wake_o}, 32'h1);
		check({24'h0, far.rx}, 32'h5a);
		sleep_i <= 1'b0;
		rd(spp_pkg::IDX_FLAGS, 8'h08);
		check({31'h0, wake_o}, 32'h0);
		far.load(8'h96, 1'b0);
		far.frame(8, 800);
		repeat (8) @(posedge clk_i);
		rd(spp_pkg::IDX_CTRL, 8'h65);
		rd(spp_pkg::IDX_BUF, 8'hc3);
		$display("test free slave done");
		wr(spp_pkg::IDX_CTRL, 8'h04);
		wr(spp_pkg::IDX_CTRL, 8'h24);
		repeat (8) @(posedge clk_i);
		check({31'h0, sdo_oe_o}, 32'h0);
		wr(spp_pkg::IDX_BUF, 8'h3c);
		far.ss_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		check({31'h0, sdo_oe_o}, 32'h1);
		far.load(8'h81, 1'b0);
		far.frame(3, 800);
		repeat (8) @(posedge clk_i);
		check({31'h0, sdo_oe_o}, 32'h0);
		wr(spp_pkg::IDX_BUF, 8'h3c);
		far.load(8'h81, 1'b0);
		far.frame(8, 800);
		repeat (8) @(posedge clk_i);
		rd(spp_pkg::IDX_BUF, 8'h81);
		check({24'h0, far.rx}, 32'h3c);
		$display("test gated slave done");
		conclude();
	end
endmodule : testbench
